// ---- design/fpd_panel_ctrl.sv ----
// Front panel controller: bar display, keypad, status outputs, release logic.
// Assumes a register master on the plain port and synchronous panel inputs.
//
// What this block does
// - Drive eleven bar positions, left to right
// - Voltage bar: flashing or steady half-steps
// - Plus/minus briefly shows voltage setpoint
// - Frequency: one of nine positions lit
// - Balance centred on middle bar position
// - Centre only zero, left negative, right positive
// - Pollution mode lights one connection indicator
// - Connection indicators dark outside pollution mode
// - Fault output high only ready, no error
// - Signal output follows selected signal mode
// - Either hardware release input grants release
// - Automatic option sets release after initialisation
// - Local option: on/off key toggles release
// - Station-held release blocks local clearing
// - Fieldbus option: command sets or clears release
// - Key lock ignores keys; bus failure clears
// - Select key advances mode; indicator steady
// - Plus/minus step connection in pollution mode
// - Display changes on press, repeat, no setup
// - High voltage indicator follows high voltage
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fpd_panel_ctrl
    import fpd_pkg::*;
#(
    parameter int unsigned REPEAT_DELAY_CYC = ms_to_cyc(REPEAT_DELAY_MS),
    parameter int unsigned REPEAT_RATE_CYC  = ms_to_cyc(REPEAT_RATE_MS),
    parameter int unsigned PREVIEW_CYC      = ms_to_cyc(PREVIEW_MS),
    parameter int unsigned BLINK_CYC        = ms_to_cyc(BLINK_MS)
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [3:0]       addr_i,
    input  wire logic [31:0]      wdata_i,
    input  wire logic             wr_stb_i,
    input  wire logic             rd_stb_i,
    output logic [31:0]           rdata_o,
    input  wire fpd_keys_t        keys_i,
    input  wire logic             setup_active_i,
    input  wire logic             fieldbus_fail_i,
    input  wire logic             fb_rel_valid_i,
    input  wire logic             fb_rel_set_i,
    input  wire logic             visu_rel_hold_i,
    input  wire logic             init_done_i,
    input  wire logic             hw_release1_i,
    input  wire logic             hw_release2_i,
    input  wire logic             error_i,
    input  wire logic             ready_i,
    input  wire logic             warning_i,
    input  wire logic             pollution_i,
    output logic [BAR_W-1:0]      bar_o,
    output logic [3:0]            mode_ind_o,
    output logic [NUM_CONN-1:0]   conn_ind_o,
    output logic                  high_voltage_indicator_o,
    output logic                  hv_enable_o,
    output logic                  fault_o,
    output logic                  signal_o
);
    fpd_ctrl_t          ctrl;
    logic [31:0]        setpt;
    logic [31:0]        actual;
    fpd_mode_t          mode;
    fpd_mode_t          next_mode;
    logic [1:0]         conn;
    logic [31:0]        prev_cnt;
    logic [31:0]        blink_cnt;
    logic               blink_off;
    logic               onoff_q;
    logic               sw_rel;
    logic               accept;
    logic               onoff_press;
    logic               hw_ok;
    logic               sw_ok;
    logic               next_hv;
    logic               preview;
    logic [2:0]         keys_v;
    logic [2:0]         step;
    logic [4:0]         enc_volt;
    logic [3:0]         enc_poll;
    logic [BAR_W-1:0]   enc_bar;
    logic [BAR_W-1:0]   enc_flash;

    function automatic fpd_mode_t mode_after(input fpd_mode_t m);
        unique case (m)
            MODE_KV:   return MODE_HZ;
            MODE_HZ:   return MODE_POLL;
            MODE_POLL: return MODE_BAL;
            MODE_BAL:  return MODE_KV;
            default:   return MODE_KV;
        endcase
    endfunction

    // Select, plus and minus are dead while locked or while the setup menu owns them; on/off is dead only while locked
    assign accept      = ~ctrl.key_lock & ~setup_active_i;
    assign onoff_press = keys_i.onoff & ~onoff_q & ~ctrl.key_lock;
    assign keys_v      = {keys_i.sel, keys_i.minus, keys_i.plus};
    assign preview     = (prev_cnt != 32'h0000_0000);
    for (genvar k = 0; k < 3; k++) begin : g_key
        fpd_key_rpt #(
            .DELAY_CYC (REPEAT_DELAY_CYC),
            .RATE_CYC  (REPEAT_RATE_CYC)
        ) u_key (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .key_i     (keys_v[k]),
            .enable_i  (accept),
            .step_o    (step[k])
        );
    end

    // Register file; the fieldbus failure wins over a write that sets the lock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl   <= fpd_ctrl_t'(CTRL_RST);
            setpt  <= ZERO_W;
            actual <= ZERO_W;
        end else begin
            if (wr_stb_i && addr_i == REG_CTRL) begin
                ctrl <= fpd_ctrl_t'(wdata_i);
                ctrl.rsvd <= '0;
            end
            if (wr_stb_i && addr_i == REG_SETPT) begin
                setpt <= wdata_i;
            end
            if (wr_stb_i && addr_i == REG_ACTUAL) begin
                actual <= wdata_i;
            end
            if (fieldbus_fail_i) begin
                ctrl.key_lock <= 1'b0;
            end
        end
    end

    always_comb begin
        next_mode = mode;
        if (step[2] && accept) begin
            next_mode = mode_after(mode);
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode <= MODE_KV;
        end else begin
            mode <= next_mode;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            conn <= 2'h0;
        end else if (mode == MODE_POLL && accept) begin
            if (step[0]) begin
                conn <= conn + 2'h1;
            end else if (step[1]) begin
                conn <= conn - 2'h1;
            end
        end
    end
    // Setpoint preview restarts on every step, so holding the key keeps it up
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prev_cnt <= 32'h0000_0000;
        end else if (mode == MODE_KV && accept && (step[0] || step[1])) begin
            prev_cnt <= 32'(PREVIEW_CYC);
        end else if (mode != MODE_KV) begin
            prev_cnt <= 32'h0000_0000;
        end else if (preview) begin
            prev_cnt <= prev_cnt - 32'h0000_0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            blink_cnt <= 32'h0000_0000;
            blink_off <= 1'b0;
        end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
            blink_cnt <= 32'h0000_0000;
            blink_off <= ~blink_off;
        end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
        end
    end
    // Software release; the station hold outranks the local key
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            onoff_q <= 1'b0;
            sw_rel  <= 1'b0;
        end else begin
            onoff_q <= keys_i.onoff;
            unique case (ctrl.swr_opt)
                SWR_AUTO: begin
                    if (init_done_i) begin
                        sw_rel <= 1'b1;
                    end
                end
                SWR_LOCAL: begin
                    if (visu_rel_hold_i) begin
                        sw_rel <= 1'b1;
                    end else if (onoff_press) begin
                        sw_rel <= ~sw_rel;
                    end
                end
                SWR_BUS: begin
                    if (fb_rel_valid_i) begin
                        sw_rel <= fb_rel_set_i;
                    end
                end
                SWR_NONE: sw_rel <= 1'b0;
            endcase
        end
    end

    assign hw_ok   = ~ctrl.hw_rel_en | hw_release1_i | hw_release2_i;
    assign sw_ok   = (ctrl.swr_opt == SWR_NONE) | sw_rel;
    assign next_hv = hw_ok & sw_ok & ~ctrl.block_hv;
    assign enc_volt = preview ? setpt[4:0] : actual[20:16];
    assign enc_poll = actual[conn*4 +: 4];
    fpd_bar_enc u_enc (
        .mode_i  (mode),
        .volt_i  (enc_volt),
        .freq_i  (setpt[11:8]),
        .bal_i   (setpt[19:16]),
        .poll_i  (enc_poll),
        .bar_o   (enc_bar),
        .flash_o (enc_flash)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bar_o      <= '0;
            mode_ind_o <= 4'h0;
            conn_ind_o <= '0;
        end else begin
            bar_o      <= enc_bar & ~(enc_flash & {BAR_W{blink_off}});
            mode_ind_o <= next_mode;
            conn_ind_o <= (next_mode == MODE_POLL) ? 4'(4'h1 << conn) : 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hv_enable_o              <= 1'b0;
            high_voltage_indicator_o <= 1'b0;
            fault_o                  <= 1'b0;
            signal_o                 <= 1'b0;
        end else begin
            hv_enable_o              <= next_hv;
            high_voltage_indicator_o <= next_hv;
            fault_o                  <= ready_i & ~error_i;
            unique case (ctrl.sig_mode)
                SIG_HV:   signal_o <= next_hv;
                SIG_WARN: signal_o <= warning_i;
                SIG_POLL: signal_o <= pollution_i;
                SIG_OFF:  signal_o <= 1'b0;
            endcase
        end
    end

    // Read data live for one cycle only; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rd_stb_i) begin
            rdata_o <= ZERO_W;
        end else begin
            unique case (addr_i)
                REG_CTRL:   rdata_o <= ctrl;
                REG_SETPT:  rdata_o <= setpt;
                REG_ACTUAL: rdata_o <= actual;
                REG_STATUS: rdata_o <= {23'h0, preview, hv_enable_o, sw_rel, conn, mode};
                default:    rdata_o <= ZERO_W;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_kv_single;
        mode == MODE_KV |=> $onehot0(bar_o);
    endproperty
    a_kv_single: assert property (p_kv_single) else $error("kv bar not single");
    // Codes above the top step are clamped, so only in-range codes map by shift
    property p_kv_steady;
        mode == MODE_KV && $stable(mode) && !preview && actual[16] && actual[20:16] <= VOLT_MAX
            |=> bar_o == 11'(11'h001 << $past(actual[20:17]));
    endproperty
    a_kv_steady: assert property (p_kv_steady) else $error("kv steady wrong");
    property p_preview;
        mode == MODE_KV && accept && step[0] && !step[2] |=> preview [*8];
    endproperty
    a_preview: assert property (p_preview) else $error("no preview");
    property p_hz_pos;
        mode == MODE_HZ && next_mode == MODE_HZ |=> $onehot(bar_o) && bar_o[10:9] == 2'h0;
    endproperty
    a_hz_pos: assert property (p_hz_pos) else $error("hz bar wrong");
    property p_bal_centre;
        mode == MODE_BAL && next_mode == MODE_BAL |=> bar_o[BAR_CENTRE];
    endproperty
    a_bal_centre: assert property (p_bal_centre) else $error("centre dark");
    property p_conn_on;
        next_mode == MODE_POLL |=> $onehot(conn_ind_o);
    endproperty
    a_conn_on: assert property (p_conn_on) else $error("no connection lit");
    property p_conn_off;
        next_mode != MODE_POLL |=> conn_ind_o == 4'h0;
    endproperty
    a_conn_off: assert property (p_conn_off) else $error("connection lit");
    property p_fault;
        ##1 fault_o == ($past(ready_i) && !$past(error_i));
    endproperty
    a_fault: assert property (p_fault) else $error("fault wrong");
    property p_sig_warn;
        ctrl.sig_mode == SIG_WARN |=> signal_o == $past(warning_i);
    endproperty
    a_sig_warn: assert property (p_sig_warn) else $error("signal wrong");
    property p_hw_gate;
        ctrl.hw_rel_en && !hw_release1_i && !hw_release2_i |=> !hv_enable_o;
    endproperty
    a_hw_gate: assert property (p_hw_gate) else $error("hv without hw");
    property p_block;
        ctrl.block_hv |=> !hv_enable_o;
    endproperty
    a_block: assert property (p_block) else $error("hv while blocked");
    property p_auto;
        ctrl.swr_opt == SWR_AUTO && init_done_i |=> sw_rel;
    endproperty
    a_auto: assert property (p_auto) else $error("no auto release");
    property p_toggle;
        ctrl.swr_opt == SWR_LOCAL && onoff_press && !visu_rel_hold_i |=> sw_rel != $past(sw_rel);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    property p_visu;
        ctrl.swr_opt == SWR_LOCAL && visu_rel_hold_i |=> sw_rel;
    endproperty
    a_visu: assert property (p_visu) else $error("visu hold lost");
    property p_bus;
        ctrl.swr_opt == SWR_BUS && fb_rel_valid_i |=> sw_rel == $past(fb_rel_set_i);
    endproperty
    a_bus: assert property (p_bus) else $error("bus release wrong");
    property p_unlock;
        fieldbus_fail_i |=> !ctrl.key_lock;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock kept");
    property p_mode_step;
        step[2] && accept |=> mode != $past(mode) && mode_ind_o == mode;
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode not stepped");
    property p_conn_step;
        mode == MODE_POLL && accept && step[0] |=> conn == $past(conn) + 2'h1;
    endproperty
    a_conn_step: assert property (p_conn_step) else $error("conn not stepped");
    property p_setup_hold;
        setup_active_i |=> $stable(mode);
    endproperty
    a_setup_hold: assert property (p_setup_hold) else $error("mode in setup");
    property p_hv_ind;
        high_voltage_indicator_o == hv_enable_o;
    endproperty
    a_hv_ind: assert property (p_hv_ind) else $error("hv indicator");
    c_poll: cover property (mode == MODE_POLL ##1 step[0]);
    c_preview: cover property (preview ##1 !preview);
    c_toggle: cover property (onoff_press ##1 sw_rel);
    c_hv: cover property (!hv_enable_o ##1 hv_enable_o);
endmodule
`default_nettype wire

// ---- design/fpd_pkg.sv ----
// Shared constants, register map and types of the front panel controller.
// Assumes a single 10 MHz system clock; no other file defines these names.
package fpd_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned REPEAT_DELAY_MS = 500;
    localparam int unsigned REPEAT_RATE_MS  = 100;
    localparam int unsigned PREVIEW_MS      = 2000;
    localparam int unsigned BLINK_MS        = 250;

    function automatic int unsigned ms_to_cyc(input int unsigned ms);
        return (ms * CYC_PER_MS == 0) ? 1 : ms * CYC_PER_MS;
    endfunction

    localparam int          BAR_W      = 11;
    localparam int          NUM_CONN   = 4;
    localparam int          BAR_CENTRE = 5;
    localparam logic [4:0]  VOLT_MAX   = 5'h13;
    localparam logic [3:0]  FREQ_MAX   = 4'h8;
    localparam logic [3:0]  POLL_MAX   = 4'hB;
    localparam logic signed [3:0] BAL_MAX = 4'sh5;

    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_SETPT  = 4'h1;
    localparam logic [3:0]  REG_ACTUAL = 4'h2;
    localparam logic [3:0]  REG_STATUS = 4'h3;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0004;
    localparam logic [31:0] ZERO_W     = 32'h0000_0000;

    typedef enum logic [3:0] {
        MODE_KV   = 4'b0001,
        MODE_HZ   = 4'b0010,
        MODE_POLL = 4'b0100,
        MODE_BAL  = 4'b1000
    } fpd_mode_t;

    typedef enum logic [1:0] {
        SWR_NONE  = 2'h0,
        SWR_AUTO  = 2'h1,
        SWR_LOCAL = 2'h2,
        SWR_BUS   = 2'h3
    } fpd_swr_t;

    typedef enum logic [1:0] {
        SIG_HV   = 2'h0,
        SIG_WARN = 2'h1,
        SIG_POLL = 2'h2,
        SIG_OFF  = 2'h3
    } fpd_sig_t;

    typedef struct packed {
        logic [24:0] rsvd;
        fpd_sig_t    sig_mode;
        logic        block_hv;
        logic        hw_rel_en;
        fpd_swr_t    swr_opt;
        logic        key_lock;
    } fpd_ctrl_t;

    typedef struct packed {
        logic plus;
        logic minus;
        logic sel;
        logic onoff;
    } fpd_keys_t;
endpackage

// ---- design/fpd_key_rpt.sv ----
// Key press and auto-repeat pulse generator for one panel key.
// Assumes key_i is already debounced and synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fpd_key_rpt #(
    parameter int unsigned DELAY_CYC = 5000,
    parameter int unsigned RATE_CYC  = 1000
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic key_i,
    input  wire logic enable_i,
    output logic      step_o
);
    logic        held;
    logic [31:0] cnt;
    wire  logic  act = key_i & enable_i;

    // First step on the press, then repeat after a longer initial wait
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            held   <= 1'b0;
            cnt    <= 32'h0000_0000;
            step_o <= 1'b0;
        end else begin
            held   <= act;
            step_o <= 1'b0;
            if (!act) begin
                cnt <= 32'h0000_0000;
            end else if (!held) begin
                step_o <= 1'b1;
                cnt    <= 32'(DELAY_CYC - 1);
            end else if (cnt == 32'h0000_0000) begin
                step_o <= 1'b1;
                cnt    <= 32'(RATE_CYC - 1);
            end else begin
                cnt <= cnt - 32'h0000_0001;
            end
        end
    end

    property p_no_double_step;
        @(posedge clk_i) disable iff (sys_rst_i) step_o |=> !step_o;
    endproperty
    a_no_double_step: assert property (p_no_double_step) else $error("step twice");
endmodule
`default_nettype wire

// ---- design/fpd_bar_enc.sv ----
// Maps the selected display value onto the 11-position bar and its flash mask.
// Pure decode; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module fpd_bar_enc
    import fpd_pkg::*;
(
    input  wire fpd_mode_t          mode_i,
    input  wire logic [4:0]         volt_i,
    input  wire logic [3:0]         freq_i,
    input  wire logic signed [3:0]  bal_i,
    input  wire logic [3:0]         poll_i,
    output logic [BAR_W-1:0]        bar_o,
    output logic [BAR_W-1:0]        flash_o
);
    logic [4:0]        v;
    logic [3:0]        f;
    logic [3:0]        p;
    logic signed [4:0] b;

    always_comb begin
        v = (volt_i > VOLT_MAX) ? VOLT_MAX : volt_i;
        f = (freq_i > FREQ_MAX) ? FREQ_MAX : freq_i;
        p = (poll_i > POLL_MAX) ? POLL_MAX : poll_i;
        b = (bal_i > BAL_MAX) ? 5'(BAL_MAX) : (bal_i < -BAL_MAX) ? -5'(BAL_MAX) : 5'(bal_i);
        bar_o   = '0;
        flash_o = '0;
        unique case (mode_i)
            MODE_KV: begin
                // Even code is the lower half-step of a position, shown flashing
                bar_o[v[4:1]]   = 1'b1;
                flash_o[v[4:1]] = ~v[0];
            end
            MODE_HZ: bar_o[f] = 1'b1;
            MODE_POLL: begin
                for (int i = 0; i < BAR_W; i++) begin
                    bar_o[i] = (i < int'(p));
                end
            end
            MODE_BAL: begin
                for (int i = 0; i < BAR_W; i++) begin
                    // Centre alone is zero; the run grows toward the sign
                    bar_o[i] = (i == BAR_CENTRE)
                        || (b < 0 && i < BAR_CENTRE && i >= BAR_CENTRE + int'(b))
                        || (b > 0 && i > BAR_CENTRE && i <= BAR_CENTRE + int'(b));
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- bench/fpd_fb_model.sv ----
// Fieldbus master stand-in that issues release commands on request.
// Assumes the bench raises go_i for one cycle with the wanted value.
`timescale 1ns/1ps
`default_nettype none
module fpd_fb_model (
    input  wire logic clk_i,
    input  wire logic go_i,
    input  wire logic set_i,
    output logic      valid_o,
    output logic      set_o
);
    // Value is inverted outside the strobe so a stale level is never trusted
    always_ff @(posedge clk_i) begin
        valid_o <= go_i;
        set_o   <= go_i ? set_i : ~set_i;
    end
endmodule
`default_nettype wire

// ---- bench/front_panel_display_release_ctrl_bench.sv ----
// Self-checking bench of the front panel controller.
// Assumes the design files and the fieldbus stand-in are compiled first.
`timescale 1ns/1ps
`default_nettype none
module front_panel_display_release_ctrl_bench
    import fpd_pkg::*;
;
    logic clk_i, sys_rst_i, wr_stb_i, rd_stb_i, setup_active_i, fieldbus_fail_i;
    logic fb_rel_valid_i, fb_rel_set_i, visu_rel_hold_i, init_done_i, hw_release1_i;
    logic hw_release2_i, error_i, ready_i, warning_i, pollution_i, fb_go, fb_set, e;
    logic high_voltage_indicator_o, hv_enable_o, fault_o, signal_o;
    logic [3:0] addr_i, mode_ind_o, conn_ind_o;
    logic [31:0] wdata_i, rdata_o, d, r;
    logic [BAR_W-1:0] bar_o, o, a;
    fpd_keys_t keys_i;
    int n_fail, comparisons, i;

    fpd_panel_ctrl #(.REPEAT_DELAY_CYC(20), .REPEAT_RATE_CYC(5), .PREVIEW_CYC(30),
        .BLINK_CYC(4)) u_dut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_stb_i,
        .rd_stb_i, .rdata_o, .keys_i, .setup_active_i, .fieldbus_fail_i,
        .fb_rel_valid_i, .fb_rel_set_i, .visu_rel_hold_i, .init_done_i,
        .hw_release1_i, .hw_release2_i, .error_i, .ready_i, .warning_i, .pollution_i,
        .bar_o, .mode_ind_o, .conn_ind_o, .high_voltage_indicator_o, .hv_enable_o,
        .fault_o, .signal_o);
    fpd_fb_model u_fb (.clk_i, .go_i(fb_go), .set_i(fb_set), .valid_o(fb_rel_valid_i),
        .set_o(fb_rel_set_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Centre always lit, run grows toward the sign of the balance
    function automatic logic [BAR_W-1:0] bal_exp(input int v);
        logic [BAR_W-1:0] b;
        b = '0;
        for (int k = 0; k < BAR_W; k++) begin
            b[k] = (k == 5) || (v > 0 && k > 5 && k <= 5 + v) || (v < 0 && k < 5 && k >= 5 + v);
        end
        return b;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
        addr_i   <= ad;
        wdata_i  <= dt;
        wr_stb_i <= 1'b1;
        cyc(1);
        wr_stb_i <= 1'b0;
        cyc(1);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] ad);
        addr_i   <= ad;
        rd_stb_i <= 1'b1;
        cyc(1);
        rd_stb_i <= 1'b0;
        cyc(1);
        d = rdata_o;
    endtask

    task automatic press(input int k);
        keys_i[k] <= 1'b1;
        cyc(2);
        keys_i[k] <= 1'b0;
        cyc(4);
    endtask

    task automatic bus(input logic v);
        fb_go  <= 1'b1;
        fb_set <= v;
        cyc(1);
        fb_go  <= 1'b0;
        cyc(4);
    endtask

    initial begin
        cyc(20000);
        n_fail++;
        finish_test();
    end

    initial begin
        {wr_stb_i, rd_stb_i, setup_active_i, fieldbus_fail_i, visu_rel_hold_i} = '0;
        {init_done_i, hw_release1_i, hw_release2_i, error_i, ready_i} = '0;
        {warning_i, pollution_i, fb_go, fb_set} = '0;
        addr_i = '0;
        wdata_i = '0;
        keys_i = '0;
        r = 32'hC4A2;
        sys_rst_i = 1'b1;
        cyc(4);
        sys_rst_i <= 1'b0;
        cyc(2);
        chk("mode_rst", mode_ind_o, 32'h1);
        chk("hv_rst", hv_enable_o, 32'h0);
        rd(REG_CTRL);
        chk("ctrl_rst", d, CTRL_RST);
        rd(4'h5);
        chk("unmapped", d, ZERO_W);
        for (i = 1; i <= 4; i++) begin
            press(1);
            chk("mode", mode_ind_o, 32'h1 << (i % 4));
            chk("conn", conn_ind_o, (i % 4 == 2) ? 32'h1 : 32'h0);
        end
        for (i = 0; i < 20; i++) begin
            wr(REG_ACTUAL, i << 16);
            cyc(3);
            o = '0;
            a = '1;
            repeat (10) begin
                cyc(1);
                o |= bar_o;
                a &= bar_o;
            end
            chk("volt_any", o, 32'h1 << (i / 2));
            chk("volt_all", a, i[0] ? 32'h1 << (i / 2) : 32'h0);
        end
        wr(REG_ACTUAL, 32'h0001_0000);
        wr(REG_SETPT, 32'h0000_0013);
        press(3);
        chk("preview", bar_o, 32'h200);
        cyc(40);
        chk("preview_end", bar_o, 32'h1);
        press(1);
        for (i = 0; i < 9; i++) begin
            wr(REG_SETPT, i << 8);
            cyc(3);
            chk("freq", bar_o, 32'h1 << i);
        end
        press(1);
        chk("conn_first", conn_ind_o, 32'h1);
        keys_i.plus <= 1'b1;
        cyc(28);
        keys_i.plus <= 1'b0;
        cyc(4);
        chk("conn_repeat", conn_ind_o, 32'h8);
        press(2);
        chk("conn_minus", conn_ind_o, 32'h4);
        press(1);
        for (int v = -5; v <= 5; v++) begin
            wr(REG_SETPT, {12'h0, v[3:0], 16'h0});
            cyc(3);
            chk("balance", bar_o, bal_exp(v));
        end
        setup_active_i <= 1'b1;
        press(1);
        chk("setup_blk", mode_ind_o, 32'h8);
        setup_active_i <= 1'b0;
        wr(REG_CTRL, 32'h5);
        press(1);
        chk("lock_blk", mode_ind_o, 32'h8);
        fieldbus_fail_i <= 1'b1;
        cyc(1);
        fieldbus_fail_i <= 1'b0;
        press(1);
        chk("lock_clr", mode_ind_o, 32'h1);
        wr(REG_CTRL, 32'hFFFF_FFFE);
        rd(REG_CTRL);
        chk("ctrl_rb", d, 32'h7E);
        for (i = 0; i < 40; i++) begin
            r = lfsr(r);
            wr(REG_CTRL, {25'h0, r[6:3], 3'h0});
            {pollution_i, warning_i, ready_i, error_i} <= r[12:9];
            {hw_release2_i, hw_release1_i} <= r[8:7];
            cyc(4);
            e = (!r[3] || r[7] || r[8]) && !r[4];
            chk("hv", hv_enable_o, e);
            chk("hv_ind", high_voltage_indicator_o, e);
            chk("fault", fault_o, r[10] & !r[9]);
            chk("signal", signal_o, r[6] ? (!r[5] & r[12]) : (r[5] ? r[11] : e));
        end
        wr(REG_CTRL, CTRL_RST);
        press(0);
        chk("local_on", hv_enable_o, 32'h1);
        visu_rel_hold_i <= 1'b1;
        press(0);
        chk("visu_hold", hv_enable_o, 32'h1);
        visu_rel_hold_i <= 1'b0;
        press(0);
        chk("local_off", hv_enable_o, 32'h0);
        wr(REG_CTRL, 32'h6);
        for (i = 0; i < 3; i++) begin
            bus(i[0]);
            chk("bus_rel", hv_enable_o, i[0]);
        end
        wr(REG_CTRL, 32'h2);
        cyc(3);
        chk("auto_wait", hv_enable_o, 32'h0);
        init_done_i <= 1'b1;
        cyc(4);
        chk("auto_set", hv_enable_o, 32'h1);
        finish_test();
    end
endmodule
`default_nettype wire
